/* logic/power_mode_controller.v */
// Operating-mode controller: sleep, standby and active, rail sequencing
// by pin order or by programmed strobe order, fault shutdown.
// Assumes faults arrive on mclk; wake and enable pins are asynchronous.
//
// Design decisions made here: the placing of the registers and strobed register access.
`timescale 1ns/1ps
`include "power_mode_regs.vh"
module power_mode_controller #(
  parameter WAKE_DELAY_CYC = `WAKE_DELAY_CYC,
  parameter UNIT_CYC       = `DELAY_UNIT_CYC,
  parameter TW             = 22
) (
  input  wire        mclk,
  input  wire        rst_n,
  input  wire        wake_pin,
  input  wire [3:0]  rail_enable_bus,
  input  wire        input_undervoltage_lockout,
  input  wire        positive_boost_undervoltage,
  input  wire        inverting_converter_undervoltage,
  input  wire        thermal_shutdown_event,
  input  wire [3:0]  reg_addr,
  input  wire [7:0]  reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [7:0]  reg_rdata,
  output wire [1:0]  mode,
  output wire        support_on,
  output wire        negative_source_regulator_en,
  output wire        backplane_bias_driver_en,
  output wire        negative_gate_pump_en,
  output wire        positive_source_regulator_en,
  output wire        positive_gate_pump_en,
  output wire        seq_busy
);
  // Sequencer states
  localparam [2:0] ST_SLEEP   = 3'h0;
  localparam [2:0] ST_STANDBY = 3'h1;
  localparam [2:0] ST_ACTIVE  = 3'h2;
  localparam [2:0] ST_WAIT    = 3'h3;
  localparam [2:0] ST_UP      = 3'h4;
  localparam [2:0] ST_DOWN    = 3'h5;

  reg  [2:0]    st_r;
  reg  [2:0]    st_nxt;
  reg  [3:0]    rails_r;
  reg  [3:0]    rails_nxt;
  reg  [1:0]    step_r;
  reg  [1:0]    step_nxt;
  reg           to_sleep_r;
  reg           to_sleep_nxt;
  reg  [7:0]    order_r;
  reg  [7:0]    dly_lo_r;
  reg  [7:0]    dly_hi_r;
  reg           req_up_r;
  reg           req_idle_r;
  reg           tmr_load;
  reg  [TW-1:0] tmr_val;

  wire [3:0]    en_lvl;
  wire [3:0]    en_rise;
  wire [3:0]    en_fall;
  wire          wake_lvl;
  wire          wake_rise;
  wire          wake_fall;
  wire          tmr_busy;
  wire          tmr_done;
  wire          fault;
  wire          sleeping;

  // Wake and enable pins through one synchroniser bank
  pin_sync #(.W(5)) u_sync (
    .mclk      (mclk),
    .rst_n     (rst_n),
    .pin_in    ({wake_pin, rail_enable_bus}),
    .level_out ({wake_lvl, en_lvl}),
    .rise_out  ({wake_rise, en_rise}),
    .fall_out  ({wake_fall, en_fall})
  );

  // Shared wait timer for the wake delay and inter-strobe delays
  delay_timer #(.W(TW)) u_tmr (
    .mclk     (mclk),
    .rst_n    (rst_n),
    .load     (tmr_load),
    .clear    (fault || !wake_lvl),
    .count_in (tmr_val),
    .busy     (tmr_busy),
    .done     (tmr_done)
  );

  assign fault = input_undervoltage_lockout | positive_boost_undervoltage |
                 inverting_converter_undervoltage |
                 thermal_shutdown_event;
  assign sleeping = (st_r == ST_SLEEP);

  // Rails whose strobe slot equals s
  function [3:0] slot_rails;
    input [7:0] ord;
    input [1:0] s;
    integer i;
    begin
      slot_rails = 4'h0;
      for (i = 0; i < 4; i = i + 1)
        slot_rails[i] = (ord[2*i +: 2] == s);
    end
  endfunction

  // Delay before strobe s, in units of UNIT_CYC
  function [3:0] slot_delay;
    input [1:0] s;
    begin
      case (s)
        2'h0:    slot_delay = dly_lo_r[3:0];
        2'h1:    slot_delay = dly_lo_r[7:4];
        2'h2:    slot_delay = dly_hi_r[3:0];
        default: slot_delay = dly_hi_r[7:4];
      endcase
    end
  endfunction

  // Registers; held at defaults and deaf while asleep
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      order_r    <= `SEQ_ORDER_RESET;
      dly_lo_r   <= `SEQ_DELAY_RESET;
      dly_hi_r   <= `SEQ_DELAY_RESET;
      req_up_r   <= 1'b0;
      req_idle_r <= 1'b0;
    end else if (sleeping) begin
      order_r    <= `SEQ_ORDER_RESET;
      dly_lo_r   <= `SEQ_DELAY_RESET;
      dly_hi_r   <= `SEQ_DELAY_RESET;
      req_up_r   <= 1'b0;
      req_idle_r <= 1'b0;
    end else begin
      // Requests are one-shot: consumed the next cycle
      req_up_r   <= reg_wr && reg_addr == `ADDR_CONTROL &&
                    reg_wdata[`CTL_POWERUP_BIT];
      req_idle_r <= reg_wr && reg_addr == `ADDR_CONTROL &&
                    reg_wdata[`CTL_IDLE_BIT];
      if (reg_wr && reg_addr == `ADDR_SEQ_ORDER)
        order_r <= reg_wdata;
      if (reg_wr && reg_addr == `ADDR_SEQ_DELAY_LO)
        dly_lo_r <= reg_wdata;
      if (reg_wr && reg_addr == `ADDR_SEQ_DELAY_HI)
        dly_hi_r <= reg_wdata;
    end
  end

  // Read port: data one cycle after the strobe, zero when asleep
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n)
      reg_rdata <= 8'h00;
    else if (!reg_rd || sleeping)
      reg_rdata <= 8'h00;
    else
      case (reg_addr)
        `ADDR_SEQ_ORDER:    reg_rdata <= order_r;
        `ADDR_SEQ_DELAY_LO: reg_rdata <= dly_lo_r;
        `ADDR_SEQ_DELAY_HI: reg_rdata <= dly_hi_r;
        `ADDR_STATUS:       reg_rdata <= {fault, st_r, rails_r};
        default:            reg_rdata <= 8'h00;
      endcase
  end

  // Mode sequencer
  always @* begin
    st_nxt       = st_r;
    rails_nxt    = rails_r;
    step_nxt     = step_r;
    to_sleep_nxt = to_sleep_r;
    tmr_load     = 1'b0;
    tmr_val      = {TW{1'b0}};
    case (st_r)
      ST_SLEEP: begin
        rails_nxt = 4'h0;
        if (wake_rise && en_lvl != 4'h0) begin
          st_nxt   = ST_WAIT;
          tmr_load = 1'b1;
          tmr_val  = WAKE_DELAY_CYC[TW-1:0];
        end else if (wake_rise)
          st_nxt = ST_STANDBY;
      end
      ST_STANDBY: begin
        rails_nxt = 4'h0;
        if (!wake_lvl)
          st_nxt = ST_SLEEP;
        else if (fault)
          st_nxt = ST_STANDBY;
        else if (req_up_r) begin
          st_nxt   = ST_UP;
          step_nxt = 2'h0;
          tmr_load = 1'b1;
          tmr_val  = {{(TW-4){1'b0}}, slot_delay(2'h0)} *
                     UNIT_CYC[TW-1:0] + {{(TW-1){1'b0}}, 1'b1};
        end else if (en_rise != 4'h0) begin
          st_nxt    = ST_ACTIVE;
          rails_nxt = en_rise;
        end
      end
      ST_WAIT: begin
        if (!wake_lvl || fault)
          st_nxt = wake_lvl ? ST_STANDBY : ST_SLEEP;
        else if (tmr_done) begin
          st_nxt   = ST_UP;
          step_nxt = 2'h0;
          tmr_load = 1'b1;
          tmr_val  = {{(TW-1){1'b0}}, 1'b1};
        end
      end
      ST_UP: begin
        // Enable-pin edges are not looked at here
        if (fault || !wake_lvl || req_idle_r) begin
          st_nxt       = ST_DOWN;
          to_sleep_nxt = !wake_lvl;
          step_nxt     = 2'h3;
          tmr_load     = 1'b1;
          tmr_val      = {{(TW-1){1'b0}}, 1'b1};
        end else if (tmr_done) begin
          rails_nxt = rails_r | slot_rails(order_r, step_r);
          if (step_r == 2'h3)
            st_nxt = ST_ACTIVE;
          else begin
            step_nxt = step_r + 2'h1;
            tmr_load = 1'b1;
            tmr_val  = {{(TW-4){1'b0}}, slot_delay(step_r + 2'h1)} *
                       UNIT_CYC[TW-1:0] + {{(TW-1){1'b0}}, 1'b1};
          end
        end
      end
      ST_ACTIVE: begin
        if (fault || !wake_lvl || req_idle_r) begin
          st_nxt       = ST_DOWN;
          to_sleep_nxt = !wake_lvl;
          step_nxt     = 2'h3;
          tmr_load     = 1'b1;
          tmr_val      = {{(TW-1){1'b0}}, 1'b1};
        end else begin
          rails_nxt = (rails_r & ~en_fall) | en_rise;
          if (rails_nxt == 4'h0)
            st_nxt = ST_STANDBY;
        end
      end
      ST_DOWN: begin
        // Reverse strobe order: slot 3 first, each later slot after the previous slot's delay, or one per cycle on fault or low wake
        if (!wake_lvl)
          to_sleep_nxt = 1'b1;
        if (tmr_done || !tmr_busy) begin
          rails_nxt = rails_r & ~slot_rails(order_r, step_r);
          if (step_r == 2'h0)
            st_nxt = to_sleep_nxt ? ST_SLEEP : ST_STANDBY;
          else begin
            step_nxt = step_r - 2'h1;
            tmr_load = 1'b1;
            tmr_val  = {{(TW-4){1'b0}}, slot_delay(step_r)} *
                       UNIT_CYC[TW-1:0] + {{(TW-1){1'b0}}, 1'b1};
          end
        end
      end
      default: st_nxt = ST_SLEEP;
    endcase
  end

  // State registers; a low wake level from reset means sleep
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_r       <= ST_SLEEP;
      rails_r    <= 4'h0;
      step_r     <= 2'h0;
      to_sleep_r <= 1'b0;
    end else begin
      st_r       <= st_nxt;
      rails_r    <= rails_nxt;
      step_r     <= step_nxt;
      to_sleep_r <= (st_nxt == ST_DOWN) ? to_sleep_nxt : 1'b0;
    end
  end

  // Reported mode: active only with a rail on and no fault
  assign mode = (rails_r != 4'h0 && !fault) ? `MODE_ACTIVE :
                sleeping ? `MODE_SLEEP : `MODE_STANDBY;
  assign support_on = !sleeping;
  assign seq_busy   = (st_r == ST_UP) || (st_r == ST_WAIT);

  // Fixed rail groups per enable bit
  assign negative_source_regulator_en = rails_r[0];
  assign backplane_bias_driver_en     = rails_r[0];
  assign negative_gate_pump_en        = rails_r[1];
  assign positive_source_regulator_en = rails_r[2];
  assign positive_gate_pump_en        = rails_r[3];
endmodule // power_mode_controller

/* logic/power_mode_regs.vh */
// Constants for the operating-mode controller: register map, field
// positions, reset values, mode codes and timing figures.
// Assumes a 50 MHz mclk and a plain register port with one-cycle strobes.
// What this block does
// - Exactly three modes: sleep, standby, active
// - Sleep resets registers and ignores bus access
// - Wake pin low forces sleep
// - Standby accepts commands, all rails stay off
// - Standby when wake high, pins low, or idle
// - Faults shut rails reverse order, enter standby
// - Active reported only with rail on, no fault
// - Active: enable pin edges switch their rail
// - Wake rise with pin high: programmed power-up
// - Wake rise with pins low: enter standby
// - Wake fall in active: reverse-order shutdown, sleep
// - Rails drop as pins fall; all low gives standby
// - Idle bit in active: reverse shutdown, standby
// - Standby pin rise starts active, pin order
// - Power-up bit in standby runs programmed order
// - Wake fall with no rail goes to sleep
// - Pin n drives its fixed rail group
// - Direct wake waits 5.5 ms before first rail
// - Pin edges ignored during programmed power-up
`ifndef POWER_MODE_REGS_VH
`define POWER_MODE_REGS_VH

// Register word addresses
`define ADDR_CONTROL      4'h0
`define ADDR_SEQ_ORDER    4'h1
`define ADDR_SEQ_DELAY_LO 4'h2
`define ADDR_SEQ_DELAY_HI 4'h3
`define ADDR_STATUS       4'h4

// Control register bits (self-clearing requests)
`define CTL_POWERUP_BIT   0
`define CTL_IDLE_BIT      1

// Sequence order: 2-bit strobe slot per rail, rail n at bits 2n+1:2n
`define SEQ_ORDER_RESET   8'he4
`define SEQ_DELAY_RESET   8'h11

// Mode codes
`define MODE_SLEEP        2'h0
`define MODE_STANDBY      2'h1
`define MODE_ACTIVE       2'h2

// Timing: 50 MHz clock
`define CLK_HZ            50000000
`define WAKE_DELAY_US     5500
`define WAKE_DELAY_CYC    ((`WAKE_DELAY_US * (`CLK_HZ / 1000000)))
`define DELAY_UNIT_US     1000
`define DELAY_UNIT_CYC    ((`DELAY_UNIT_US * (`CLK_HZ / 1000000)))

`endif

/* logic/pin_sync.v */
// Three-stage synchroniser with agreement on the last two stages.
// Assumes the input is asynchronous to mclk.
`timescale 1ns/1ps
module pin_sync #(
  parameter W = 5
) (
  input  wire         mclk,
  input  wire         rst_n,
  input  wire [W-1:0] pin_in,
  output reg  [W-1:0] level_out,
  output wire [W-1:0] rise_out,
  output wire [W-1:0] fall_out
);
  reg [W-1:0] s1_r;
  reg [W-1:0] s2_r;
  reg [W-1:0] s3_r;
  reg [W-1:0] prev_r;

  // Only s2 reads s1; a level counts once s2 and s3 agree
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s1_r      <= {W{1'b0}};
      s2_r      <= {W{1'b0}};
      s3_r      <= {W{1'b0}};
      level_out <= {W{1'b0}};
      prev_r    <= {W{1'b0}};
    end else begin
      s1_r      <= pin_in;
      s2_r      <= s1_r;
      s3_r      <= s2_r;
      level_out <= (s2_r & s3_r) | (level_out & (s2_r | s3_r));
      prev_r    <= level_out;
    end
  end

  // One event per edge, seen from the filtered level
  assign rise_out = level_out & ~prev_r;
  assign fall_out = ~level_out & prev_r;
endmodule // pin_sync

/* logic/delay_timer.v */
// Load-and-count-down timer; done pulses when the count expires.
// A load restarts a running count; clear takes priority over load.
`timescale 1ns/1ps
module delay_timer #(
  parameter W = 20
) (
  input  wire         mclk,
  input  wire         rst_n,
  input  wire         load,
  input  wire         clear,
  input  wire [W-1:0] count_in,
  output wire         busy,
  output wire         done
);
  reg [W-1:0] cnt_r;

  // Clear abandons a pending wait, e.g. on a fault
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n)
      cnt_r <= {W{1'b0}};
    else if (clear)
      cnt_r <= {W{1'b0}};
    else if (load)
      cnt_r <= count_in;
    else if (cnt_r != {W{1'b0}})
      cnt_r <= cnt_r - {{(W-1){1'b0}}, 1'b1};
  end

  assign busy = (cnt_r != {W{1'b0}});
  assign done = (cnt_r == {{(W-1){1'b0}}, 1'b1}) && !clear;
endmodule // delay_timer

/* testbench/power_mode_asserts.sv */
// Concurrent checks on the mode controller, seen from its ports only.
// Assumes a wake delay parameter of at least 12 cycles.
`timescale 1ns/1ps
module power_mode_asserts #(
  parameter WAKE_DELAY_CYC = 20
) (
  input wire       mclk,
  input wire       rst_n,
  input wire       wake_pin,
  input wire [3:0] rail_enable_bus,
  input wire       input_undervoltage_lockout,
  input wire       positive_boost_undervoltage,
  input wire       inverting_converter_undervoltage,
  input wire       thermal_shutdown_event,
  input wire       reg_rd,
  input wire [7:0] reg_rdata,
  input wire [1:0] mode,
  input wire       support_on,
  input wire       negative_source_regulator_en,
  input wire       backplane_bias_driver_en,
  input wire       negative_gate_pump_en,
  input wire       positive_source_regulator_en,
  input wire       positive_gate_pump_en,
  input wire       seq_busy
);
  localparam int WD_LO = WAKE_DELAY_CYC - 4;
  wire [3:0] rails;
  wire       flt;
  // Rail vector and any fault, for compact properties
  assign rails = {positive_gate_pump_en, positive_source_regulator_en,
                  negative_gate_pump_en, negative_source_regulator_en};
  assign flt = input_undervoltage_lockout | positive_boost_undervoltage |
               inverting_converter_undervoltage | thermal_shutdown_event;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  property p_modes; mode != 2'h3; endproperty
  a_modes: assert property (p_modes) else $error("bad mode code");
  property p_sleep; mode == 2'h0 |-> !support_on && rails == 4'h0; endproperty
  a_sleep: assert property (p_sleep) else $error("sleep not off");
  property p_rd; reg_rd && mode == 2'h0 |=> reg_rdata == 8'h00; endproperty
  a_rd: assert property (p_rd) else $error("sleep read answered");
  property p_wlow; !wake_pin [*8] |-> ##[0:400] mode == 2'h0; endproperty
  a_wlow: assert property (p_wlow) else $error("no sleep");
  property p_act; mode == 2'h2 |-> rails != 4'h0 && !flt; endproperty
  a_act: assert property (p_act) else $error("bad active");
  property p_flt; $rose(flt) |-> ##[1:400] rails == 4'h0; endproperty
  a_flt: assert property (p_flt) else $error("fault kept rails");
  property p_bias;
    backplane_bias_driver_en == negative_source_regulator_en;
  endproperty
  a_bias: assert property (p_bias) else $error("bias split");
  // A rail never drops while the programmed power-up runs
  property p_busy;
    seq_busy && $past(seq_busy) |-> ($past(rails) & ~rails) == 4'h0;
  endproperty
  a_busy: assert property (p_busy) else $error("rail dropped");
  property p_wake;
    $rose(wake_pin) && rail_enable_bus != 4'h0 |->
      ##WD_LO rails == 4'h0 ##[1:200] mode == 2'h2;
  endproperty
  a_wake: assert property (p_wake) else $error("bad wake");
endmodule // power_mode_asserts

bind power_mode_controller power_mode_asserts #(
  .WAKE_DELAY_CYC(WAKE_DELAY_CYC)) u_chk (
  .mclk(mclk), .rst_n(rst_n), .wake_pin(wake_pin),
  .rail_enable_bus(rail_enable_bus),
  .input_undervoltage_lockout(input_undervoltage_lockout),
  .positive_boost_undervoltage(positive_boost_undervoltage),
  .inverting_converter_undervoltage(inverting_converter_undervoltage),
  .thermal_shutdown_event(thermal_shutdown_event),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mode(mode),
  .support_on(support_on),
  .negative_source_regulator_en(negative_source_regulator_en),
  .backplane_bias_driver_en(backplane_bias_driver_en),
  .negative_gate_pump_en(negative_gate_pump_en),
  .positive_source_regulator_en(positive_source_regulator_en),
  .positive_gate_pump_en(positive_gate_pump_en), .seq_busy(seq_busy));

/* testbench/host_model.sv */
// Host pin driver: wake pin and rail enable pins.
// Assumes one bench process calls its tasks.
`timescale 1ns/1ps
module host_model #(
  parameter LOW_HOLD = 40
) (
  input  wire       mclk,
  output reg        wake_pin,
  output reg  [3:0] rail_enable_bus
);
  // Pins start low so the device sleeps
  initial begin
    wake_pin = 1'b0;
    rail_enable_bus = 4'h0;
  end
  task set_pins(input [3:0] v);
    @(posedge mclk);
    rail_enable_bus <= v;
  endtask
  // Low time is scaled down; the bench never shortens it
  task set_wake(input v);
    @(posedge mclk);
    wake_pin <= v;
    if (!v) repeat (LOW_HOLD) @(posedge mclk);
  endtask
endmodule // host_model

/* testbench/power_mode_controller_test.sv */
// Self-checking bench for the mode controller with a host pin model.
// Assumes a 20-cycle wake delay and a 4-cycle delay unit.
`timescale 1ns/1ps
module power_mode_controller_test;
  reg         mclk;
  reg         rst_n;
  reg   [3:0] flt;
  reg   [3:0] reg_addr;
  reg   [7:0] reg_wdata;
  reg         reg_wr;
  reg         reg_rd;
  reg         rd_d;
  reg   [3:0] rails_d;
  reg   [7:0] dly;
  wire        wake_pin;
  wire  [3:0] rail_enable_bus;
  wire  [7:0] reg_rdata;
  wire  [1:0] mode;
  wire  [3:0] rails;
  wire        support_on;
  wire        bias_en;
  wire        seq_busy;
  logic [3:0] rq[$];
  logic [7:0] dq[$];
  integer     error_cnt;
  integer     total_checks;
  integer     cyc;
  integer     seed;
  integer     k;
  always #10 mclk = ~mclk;
  host_model u_host (.mclk(mclk), .wake_pin(wake_pin),
    .rail_enable_bus(rail_enable_bus));
  power_mode_controller #(.WAKE_DELAY_CYC(20), .UNIT_CYC(4)) u_dut (
    .mclk(mclk), .rst_n(rst_n), .wake_pin(wake_pin),
    .rail_enable_bus(rail_enable_bus),
    .input_undervoltage_lockout(flt[0]),
    .positive_boost_undervoltage(flt[1]),
    .inverting_converter_undervoltage(flt[2]),
    .thermal_shutdown_event(flt[3]), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .mode(mode), .support_on(support_on),
    .negative_source_regulator_en(rails[0]),
    .backplane_bias_driver_en(bias_en),
    .negative_gate_pump_en(rails[1]), .positive_source_regulator_en(rails[2]),
    .positive_gate_pump_en(rails[3]), .seq_busy(seq_busy));
  task chk(input [7:0] seen, input [7:0] exp, input string nm);
    total_checks = total_checks + 1;
    if (seen !== exp) begin
      error_cnt = error_cnt + 1;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task final_report;
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task wr(input [3:0] a, input [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task rd(input [3:0] a, input [7:0] e);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    dq.push_back(e);
    @(posedge mclk);
    reg_rd <= 1'b0;
  endtask
  task wait_mode(input [1:0] m);
    integer i;
    for (i = 0; i < 600 && mode !== m; i = i + 1)
      @(posedge mclk);
    // Let the launching edge settle before looking
    #1;
    chk({6'h00, mode}, {6'h00, m}, "mode");
    chk({7'h00, support_on}, {7'h00, m != 2'h0}, "support");
  endtask
  // Bounded wait until every noted rail step has been seen
  task wait_q;
    integer i;
    for (i = 0; i < 2000 && rq.size() != 0; i = i + 1)
      @(posedge mclk);
    chk({7'h00, rq.size() == 0}, 8'h01, "rail steps");
  endtask
  // Default slot order: rail 0 first up, rail 3 first down
  task push_seq(input up);
    if (up)
      rq = {rq, 4'h1, 4'h3, 4'h7, 4'hf};
    else
      rq = {rq, 4'h7, 4'h3, 4'h1, 4'h0};
  endtask
  // Monitor: read data one cycle after the strobe, each rail change
  always @(posedge mclk) begin
    rd_d <= reg_rd;
    rails_d <= rails;
    if (rd_d)
      chk(reg_rdata, dq.pop_front(), "read data");
    if (rails !== rails_d) begin
      chk({4'h0, rails}, {4'h0, rq.pop_front()}, "rails");
      chk({7'h00, bias_en}, {7'h00, rails[0]}, "bias");
    end
  end
  // Hang guard, far above the expected few hundred cycles
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      error_cnt = error_cnt + 1;
      final_report;
    end
  end
  initial begin
    mclk = 1'b0;
    rst_n = 1'b0;
    flt = 4'h0;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    rd_d = 1'b0;
    rails_d = 4'h0;
    error_cnt = 0;
    total_checks = 0;
    cyc = 0;
    seed = 22;
    repeat (10) @(posedge mclk);
    rst_n <= 1'b1;
    rd(4'h1, 8'h00);
    wr(4'h1, 8'h1b);
    u_host.set_wake(1'b1);
    wait_mode(2'h1);
    rd(4'h1, 8'he4);
    rd(4'h9, 8'h00);
    dly = $random(seed);
    dly = (dly & 8'h33) | 8'h11;
    wr(4'h2, dly);
    rd(4'h2, dly);
    $display("test registers done");
    push_seq(1);
    wr(4'h0, 8'h01);
    wait_q;
    wait_mode(2'h2);
    push_seq(0);
    wr(4'h0, 8'h02);
    wait_q;
    wait_mode(2'h1);
    $display("test programmed sequence done");
    rq = {rq, 4'h4, 4'h5, 4'h1, 4'h0};
    u_host.set_pins(4'h4);
    repeat (20) @(posedge mclk);
    u_host.set_pins(4'h5);
    repeat (20) @(posedge mclk);
    u_host.set_pins(4'h1);
    repeat (20) @(posedge mclk);
    u_host.set_pins(4'h0);
    wait_q;
    wait_mode(2'h1);
    $display("test pin order done");
    for (k = 0; k < 4; k = k + 1) begin
      push_seq(1);
      wr(4'h0, 8'h01);
      wait_q;
      push_seq(0);
      flt <= 4'h1 << k;
      wait_q;
      wait_mode(2'h1);
      flt <= 4'h0;
    end
    $display("test faults done");
    push_seq(1);
    wr(4'h0, 8'h01);
    wait_q;
    push_seq(0);
    u_host.set_wake(1'b0);
    wait_q;
    wait_mode(2'h0);
    u_host.set_pins(4'h3);
    push_seq(1);
    u_host.set_wake(1'b1);
    repeat (8) @(posedge mclk);
    #1;
    chk({7'h00, seq_busy}, 8'h01, "seq busy");
    u_host.set_pins(4'h1);
    wait_q;
    wait_mode(2'h2);
    rd(4'h2, 8'h11);
    $display("test wake paths done");
    final_report;
  end
endmodule // power_mode_controller_test
